// ### hdl/ebt_filter.sv
// Purpose: pin synchroniser, glitch filter and edge detector
// Assumes: input asynchronous to sys_clk_in
// Notes:   pulses last one enabled clock
`timescale 1ns/1ps
`default_nettype none
module ebt_filter (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       clk_en_in,
  // Control
  input  wire logic [1:0] flt_sel_in,
  input  wire logic       pin_in,
  // Edges
  output logic            pos_edge_out,
  output logic            neg_edge_out
);
  logic [2:0] sync_reg;
  logic       stable_reg;
  logic [3:0] run_reg;
  logic [3:0] width;

  always_comb begin
    case (flt_sel_in)
      2'b01:   width = ebt_pkg::FLT_W1;
      2'b10:   width = ebt_pkg::FLT_W2;
      2'b11:   width = ebt_pkg::FLT_W3;
      default: width = 4'h0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync_reg <= 3'h0;
    end else if (clk_en_in) begin
      sync_reg <= {sync_reg[1:0], pin_in};
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stable_reg   <= 1'b0;
      run_reg      <= 4'h0;
      pos_edge_out <= 1'b0;
      neg_edge_out <= 1'b0;
    end else if (clk_en_in) begin
      pos_edge_out <= 1'b0;
      neg_edge_out <= 1'b0;
      if (sync_reg[2] != sync_reg[1] || sync_reg[2] == stable_reg) begin
        run_reg <= 4'h0;
      end else if (run_reg >= width) begin
        stable_reg <= sync_reg[2];
        run_reg    <= 4'h0;
        pos_edge_out <= sync_reg[2];
        neg_edge_out <= !sync_reg[2];
      end else begin
        run_reg <= run_reg + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hdl/ebt_out.sv
// Purpose: timer pin routing and combination logic
// Assumes: same clock as timer core
// Notes:   registered outputs, one clock of latency
`timescale 1ns/1ps
`default_nettype none
module ebt_out (
  // Clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       clk_en_in,
  // Timer levels and control
  input  wire logic       short_level_in,
  input  wire logic       long_level_in,
  input  wire logic       short_pin_en_in,
  input  wire logic       long_pin_en_in,
  input  wire logic       comb_en_in,
  input  wire logic [1:0] comb_sel_in,
  // Pins
  output logic            short_timer_pin_out,
  output logic            long_timer_pin_out,
  output logic            combined_timer_pin_out
);
  logic comb;

  always_comb begin
    case (comb_sel_in)
      2'b00:   comb = short_level_in & long_level_in;
      2'b01:   comb = short_level_in | long_level_in;
      2'b10:   comb = ~(short_level_in & long_level_in);
      default: comb = ~(short_level_in | long_level_in);
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      short_timer_pin_out    <= 1'b0;
      long_timer_pin_out     <= 1'b0;
      combined_timer_pin_out <= 1'b0;
    end else if (clk_en_in) begin
      short_timer_pin_out    <= short_pin_en_in & short_level_in;
      long_timer_pin_out     <= long_pin_en_in & long_level_in;
      combined_timer_pin_out <= comb_en_in & comb;
    end
  end
endmodule
`default_nettype wire

// ### hdl/ebt_pkg.sv
// Purpose: constants for the eight-bit counter/timer block
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses
// Notes:   register offsets other than aux control are local choices
package ebt_pkg;
  localparam logic [7:0] ADDR_SHORT_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_LONG_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_AUX_CTRL   = 8'h0C;
  localparam logic [7:0] ADDR_LOW_CNT    = 8'h10;
  localparam logic [7:0] ADDR_HIGH_CNT   = 8'h14;
  localparam logic [7:0] ADDR_CAP_POS    = 8'h18;
  localparam logic [7:0] ADDR_CAP_NEG    = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLR    = 8'h28;
  localparam logic [7:0] ADDR_COUNTER    = 8'h2C;
  // Short control fields
  localparam int SC_ENABLE  = 7;
  localparam int SC_SINGLE  = 6;
  localparam int SC_TIMEOUT = 5;
  localparam int SC_DEMOD   = 4;
  localparam int SC_PINGPONG = 3;
  localparam int SC_IRQ_EN  = 1;
  localparam int SC_PIN_EN  = 0;
  // Mode control fields
  localparam int MC_COMB_EN = 6;
  localparam int MC_SEL_HI  = 5;
  localparam int MC_SEL_LO  = 4;
  localparam int MC_FLT_HI  = 3;
  localparam int MC_FLT_LO  = 2;
  localparam int MC_INIT    = 1;
  localparam int MC_INSEL   = 0;
  // Long control fields
  localparam int LC_ENABLE  = 7;
  localparam int LC_TIMEOUT = 5;
  localparam int LC_PIN_EN  = 0;
  localparam logic [7:0] AUX_RESET  = 8'h1F;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CNT_ALL_ONES = 8'hFF;
  // Glitch filter widths in clocks, per filter code
  localparam logic [3:0] FLT_W1 = 4'h2;
  localparam logic [3:0] FLT_W2 = 4'h4;
  localparam logic [3:0] FLT_W3 = 4'h8;
  // Interrupt status bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_W       = 2;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// ### hdl/ebt_timer.sv
// Purpose: eight-bit down-counter/timer with AXI4-Lite registers
// Assumes: one clock; long timer lives outside, seen by its level and terminal count
// Notes:   counter ticks once per enabled clock
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Edge detector pulses on selected edges
// - Filter glitches below selected width
// - Disabled output is inverse initial bit
// - Enable loads output and phase count
// - Single-pass: stop, toggle, timeout, interrupt
// - Modulo-N: first toggle silent, then repeat
// - Phase counts used at next reload
// - Zero count wraps to all-ones
// - Wrap is not a timeout
// - Demodulation captures complemented count
// - Ping-pong alternates timer enables
// - Ping-pong sets timeout each terminal
// - Control bit 0 routes timer pins
// - Combine bit drives combined pin
module ebt_timer (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        clk_en_in,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        edge_input_a_in,
  input  wire logic        edge_input_b_in,
  output logic             short_timer_pin_out,
  output logic             long_timer_pin_out,
  output logic             combined_timer_pin_out,
  // Long timer hand-off
  input  wire logic        long_level_in,
  input  wire logic        long_terminal_in,
  output logic             long_enable_out,
  // Interrupt
  output logic             irq_out
);
  typedef enum logic [1:0] {
    EBT_IDLE  = 2'b00,
    EBT_FIRST = 2'b01,
    EBT_RUN   = 2'b10,
    EBT_DONE  = 2'b11
  } ebt_state_t;

  ebt_state_t state_reg;
  logic [7:0] short_ctrl_reg;
  logic [7:0] mode_ctrl_reg;
  logic [7:0] long_ctrl_reg;
  logic [7:0] low_cnt_reg;
  logic [7:0] high_cnt_reg;
  logic [7:0] cap_pos_reg;
  logic [7:0] cap_neg_reg;
  logic [7:0] count_reg;
  logic       level_reg;
  logic       en_d_reg;
  logic [ebt_pkg::IRQ_W-1:0] stat_reg;
  logic [ebt_pkg::IRQ_W-1:0] irq_en_reg;
  logic       aw_hold_reg;
  logic       w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic       pos_edge;
  logic       neg_edge;
  logic       sel_edge;
  logic       pin_sel;
  logic       enabled;
  logic       rise_en;
  logic       terminal;
  logic       timeout_ev;
  logic       capture_ev;
  logic       wr_fire;
  logic       short_level;
  logic [ebt_pkg::IRQ_W-1:0] clr_mask;

  assign pin_sel   = mode_ctrl_reg[ebt_pkg::MC_INSEL] ? edge_input_b_in : edge_input_a_in;
  assign enabled   = short_ctrl_reg[ebt_pkg::SC_ENABLE];
  assign rise_en   = enabled & !en_d_reg;
  assign wr_fire   = aw_hold_reg & w_hold_reg & !s_axi_bvalid;
  // Edge select: 01 rising, 10 falling, 11 both
  assign sel_edge  = (pos_edge & mode_ctrl_reg[ebt_pkg::MC_SEL_LO])
                   | (neg_edge & mode_ctrl_reg[ebt_pkg::MC_SEL_HI]);
  assign terminal  = (state_reg == EBT_FIRST || state_reg == EBT_RUN) && count_reg == 8'h01;
  assign short_level = enabled ? level_reg : !mode_ctrl_reg[ebt_pkg::MC_INIT];

  ebt_filter u_filter (
    .sys_clk_in   (sys_clk_in),
    .resetn_in    (resetn_in),
    .clk_en_in    (clk_en_in),
    .flt_sel_in   (mode_ctrl_reg[ebt_pkg::MC_FLT_HI:ebt_pkg::MC_FLT_LO]),
    .pin_in       (pin_sel),
    .pos_edge_out (pos_edge),
    .neg_edge_out (neg_edge)
  );

  ebt_out u_out (
    .sys_clk_in             (sys_clk_in),
    .resetn_in              (resetn_in),
    .clk_en_in              (clk_en_in),
    .short_level_in         (short_level),
    .long_level_in          (long_level_in),
    .short_pin_en_in        (short_ctrl_reg[ebt_pkg::SC_PIN_EN]),
    .long_pin_en_in         (long_ctrl_reg[ebt_pkg::LC_PIN_EN]),
    .comb_en_in             (mode_ctrl_reg[ebt_pkg::MC_COMB_EN]),
    .comb_sel_in            (mode_ctrl_reg[ebt_pkg::MC_SEL_HI:ebt_pkg::MC_SEL_LO]),
    .short_timer_pin_out    (short_timer_pin_out),
    .long_timer_pin_out     (long_timer_pin_out),
    .combined_timer_pin_out (combined_timer_pin_out)
  );

  // Timeout raised only after the silent first pass in modulo-N
  assign timeout_ev = terminal && !short_ctrl_reg[ebt_pkg::SC_DEMOD]
                    && (short_ctrl_reg[ebt_pkg::SC_SINGLE] || short_ctrl_reg[ebt_pkg::SC_PINGPONG]
                        || state_reg == EBT_RUN);
  assign capture_ev = short_ctrl_reg[ebt_pkg::SC_DEMOD] && state_reg == EBT_RUN && sel_edge;
  assign clr_mask   = (wr_fire && aw_addr_reg == ebt_pkg::ADDR_IRQ_CLR && w_strb_reg[0])
                    ? w_data_reg[ebt_pkg::IRQ_W-1:0] : '0;

  // Counter and state
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= EBT_IDLE;
      count_reg <= 8'h00;
      level_reg <= 1'b0;
      en_d_reg  <= 1'b0;
    end else if (clk_en_in) begin
      en_d_reg <= enabled;
      if (!enabled) begin
        state_reg <= EBT_IDLE;
        // no stale level in the enable cycle
        level_reg <= mode_ctrl_reg[ebt_pkg::MC_INIT];
      end else if (rise_en) begin
        level_reg <= mode_ctrl_reg[ebt_pkg::MC_INIT];
        count_reg <= mode_ctrl_reg[ebt_pkg::MC_INIT] ? high_cnt_reg : low_cnt_reg;
        state_reg <= short_ctrl_reg[ebt_pkg::SC_DEMOD] ? EBT_DONE : EBT_FIRST;
      end else if (short_ctrl_reg[ebt_pkg::SC_DEMOD]) begin
        if (state_reg == EBT_DONE && sel_edge) begin
          state_reg <= EBT_RUN;
        end else if (state_reg == EBT_RUN) begin
          count_reg <= count_reg - 8'h01;
        end
      end else if (terminal) begin
        level_reg <= !level_reg;
        if (short_ctrl_reg[ebt_pkg::SC_SINGLE]) begin
          state_reg <= EBT_DONE;
          count_reg <= 8'h00;
        end else begin
          // reload by new level, fresh phase count
          state_reg <= EBT_RUN;
          count_reg <= level_reg ? low_cnt_reg : high_cnt_reg;
        end
      end else if (state_reg == EBT_FIRST || state_reg == EBT_RUN) begin
        count_reg <= count_reg - 8'h01;
      end
    end
  end

  // Control and count registers
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      short_ctrl_reg <= ebt_pkg::CTRL_RESET;
      mode_ctrl_reg  <= ebt_pkg::CTRL_RESET;
      long_ctrl_reg  <= ebt_pkg::CTRL_RESET;
      low_cnt_reg    <= ebt_pkg::CNT_ALL_ONES;
      high_cnt_reg   <= ebt_pkg::CNT_ALL_ONES;
      irq_en_reg     <= '0;
    end else if (clk_en_in) begin
      if (wr_fire && w_strb_reg[0]) begin
        if (aw_addr_reg == ebt_pkg::ADDR_SHORT_CTRL) begin
          short_ctrl_reg <= w_data_reg[7:0];
        end else if (aw_addr_reg == ebt_pkg::ADDR_MODE_CTRL) begin
          mode_ctrl_reg <= w_data_reg[7:0];
        end else if (aw_addr_reg == ebt_pkg::ADDR_LONG_CTRL) begin
          long_ctrl_reg <= w_data_reg[7:0];
        end else if (aw_addr_reg == ebt_pkg::ADDR_LOW_CNT) begin
          low_cnt_reg <= w_data_reg[7:0];
        end else if (aw_addr_reg == ebt_pkg::ADDR_HIGH_CNT) begin
          high_cnt_reg <= w_data_reg[7:0];
        end else if (aw_addr_reg == ebt_pkg::ADDR_IRQ_EN) begin
          irq_en_reg <= w_data_reg[ebt_pkg::IRQ_W-1:0];
        end
      end
      // hardware timeout flags win over software
      if (timeout_ev) begin
        short_ctrl_reg[ebt_pkg::SC_TIMEOUT] <= 1'b1;
      end
      if (long_terminal_in) begin
        long_ctrl_reg[ebt_pkg::LC_TIMEOUT] <= 1'b1;
      end
      // ping-pong hands the enable back and forth
      if (short_ctrl_reg[ebt_pkg::SC_PINGPONG]) begin
        if (terminal) begin
          short_ctrl_reg[ebt_pkg::SC_ENABLE] <= 1'b0;
          long_ctrl_reg[ebt_pkg::LC_ENABLE]  <= 1'b1;
        end else if (long_terminal_in) begin
          long_ctrl_reg[ebt_pkg::LC_ENABLE]  <= 1'b0;
          short_ctrl_reg[ebt_pkg::SC_ENABLE] <= 1'b1;
        end
      end else if (terminal && short_ctrl_reg[ebt_pkg::SC_SINGLE]) begin
        short_ctrl_reg[ebt_pkg::SC_ENABLE] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cap_pos_reg <= 8'h00;
      cap_neg_reg <= 8'h00;
    end else if (clk_en_in && capture_ev) begin
      if (pos_edge) begin
        cap_pos_reg <= ~count_reg;
      end else begin
        cap_neg_reg <= ~count_reg;
      end
    end
  end

  // Sticky status, set beats clear
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stat_reg <= '0;
      irq_out  <= 1'b0;
      long_enable_out <= 1'b0;
    end else if (clk_en_in) begin
      stat_reg[ebt_pkg::IRQ_TIMEOUT] <= timeout_ev | (stat_reg[ebt_pkg::IRQ_TIMEOUT]
                                        & !clr_mask[ebt_pkg::IRQ_TIMEOUT]);
      stat_reg[ebt_pkg::IRQ_CAPTURE] <= capture_ev | (stat_reg[ebt_pkg::IRQ_CAPTURE]
                                        & !clr_mask[ebt_pkg::IRQ_CAPTURE]);
      irq_out <= |(stat_reg & irq_en_reg & {1'b1, short_ctrl_reg[ebt_pkg::SC_IRQ_EN]});
      long_enable_out <= long_ctrl_reg[ebt_pkg::LC_ENABLE];
    end
  end

  // AXI write channel: address and data taken in either order
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_hold_reg   <= 1'b0;
      w_hold_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ebt_pkg::AXI_OKAY;
    end else if (clk_en_in) begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_reg  <= 1'b0;
        w_hold_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg == ebt_pkg::ADDR_SHORT_CTRL || aw_addr_reg == ebt_pkg::ADDR_MODE_CTRL
            || aw_addr_reg == ebt_pkg::ADDR_LONG_CTRL || aw_addr_reg == ebt_pkg::ADDR_AUX_CTRL
            || aw_addr_reg == ebt_pkg::ADDR_LOW_CNT || aw_addr_reg == ebt_pkg::ADDR_HIGH_CNT
            || aw_addr_reg == ebt_pkg::ADDR_IRQ_EN || aw_addr_reg == ebt_pkg::ADDR_IRQ_CLR) begin
          s_axi_bresp <= ebt_pkg::AXI_OKAY;
        end else begin
          s_axi_bresp <= ebt_pkg::AXI_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI read channel
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ebt_pkg::AXI_OKAY;
    end else if (clk_en_in) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ebt_pkg::AXI_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == ebt_pkg::ADDR_SHORT_CTRL) begin
          s_axi_rdata[7:0] <= short_ctrl_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_MODE_CTRL) begin
          s_axi_rdata[7:0] <= mode_ctrl_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_LONG_CTRL) begin
          s_axi_rdata[7:0] <= long_ctrl_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_AUX_CTRL) begin
          s_axi_rdata[7:0] <= ebt_pkg::AUX_RESET;
        end else if (s_axi_araddr == ebt_pkg::ADDR_LOW_CNT) begin
          s_axi_rdata[7:0] <= low_cnt_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_HIGH_CNT) begin
          s_axi_rdata[7:0] <= high_cnt_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_CAP_POS) begin
          s_axi_rdata[7:0] <= cap_pos_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_CAP_NEG) begin
          s_axi_rdata[7:0] <= cap_neg_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_IRQ_STAT) begin
          s_axi_rdata[ebt_pkg::IRQ_W-1:0] <= stat_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_IRQ_EN) begin
          s_axi_rdata[ebt_pkg::IRQ_W-1:0] <= irq_en_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_COUNTER) begin
          s_axi_rdata[7:0] <= count_reg;
        end else if (s_axi_araddr == ebt_pkg::ADDR_IRQ_CLR) begin
          s_axi_rdata <= 32'h0000_0000;
        end else begin
          s_axi_rresp <= ebt_pkg::AXI_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### verification/ebt_pin_model.sv
// Purpose: pin-side sources and long timer stand-in
// Assumes: shares the timer clock
// Notes:   fixed pulse train; idle pin b toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_model (
  // Clock and command
  input  wire logic sys_clk_in,
  input  wire logic go_in,
  input  wire logic level_in,
  // Pins
  output logic      edge_a_out,
  output logic      edge_b_out,
  output logic      level_out,
  output logic      terminal_out
);
  logic [7:0] t = 8'h00;
  logic [5:0] c = 6'h00;
  always @(posedge sys_clk_in) begin
    c <= c + 6'h01;
    t <= go_in ? 8'h01 : ((t == 8'h00 || t == 8'hFF) ? t : t + 8'h01);
  end
  // Three-cycle glitch, then rise, fall 20 later, rise 60 after first
  assign edge_a_out = (t >= 8'h01 && t <= 8'h03) || (t >= 8'h20 && t < 8'h34) || t >= 8'h5C;
  assign edge_b_out = c[0];
  assign level_out = level_in;
  assign terminal_out = (c == 6'h00);
endmodule
`default_nettype wire

// ### verification/ebt_timer_checker.sv
// Purpose: port-level assertions for the eight-bit timer
// Assumes: one clock, clock enable held high
// Notes:   irq may only fall soon after a register write
`timescale 1ns/1ps
`default_nettype none
module ebt_timer_checker (
  // Clock and reset
  input wire logic        sys_clk_in,
  input wire logic        resetn_in,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic        long_level_in,
  input wire logic        long_timer_pin_out,
  input wire logic        irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  logic [3:0] wr_age;
  // Saturates so an idle bus never wraps back
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in)
      wr_age <= 4'hF;
    else if (s_axi_wvalid)
      wr_age <= 4'h0;
    else if (wr_age != 4'hF)
      wr_age <= wr_age + 4'h1;
  end
  sequence s_b_done; s_axi_bvalid && s_axi_bready; endsequence
  sequence s_r_done; s_axi_rvalid && s_axi_rready; endsequence
  property p_aw_take; $rose(s_axi_awvalid) |-> ##[1:4] s_axi_awready; endproperty
  property p_w_take; $rose(s_axi_wvalid) |-> ##[1:4] s_axi_wready; endproperty
  property p_ar_take; $rose(s_axi_arvalid) |-> ##[1:4] s_axi_arready; endproperty
  property p_b_once; s_b_done |=> !s_axi_bvalid; endproperty
  property p_r_once; s_r_done |=> !s_axi_rvalid; endproperty
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_long_pin; long_timer_pin_out |-> $past(long_level_in); endproperty
  property p_irq_fall; $fell(irq_out) |-> wr_age < 4'h6; endproperty
  a_aw_take: assert property (p_aw_take)
    else $error("write address not taken");
  a_w_take: assert property (p_w_take)
    else $error("write data not taken");
  a_ar_take: assert property (p_ar_take)
    else $error("read address not taken");
  a_b_once: assert property (p_b_once)
    else $error("write answered twice");
  a_r_once: assert property (p_r_once)
    else $error("read answered twice");
  a_r_upper: assert property (p_r_upper)
    else $error("upper read bits set");
  a_long_pin: assert property (p_long_pin)
    else $error("long pin high without level");
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without a write");
endmodule
bind ebt_timer ebt_timer_checker u_chk (.*);
`default_nettype wire

// ### verification/eight_bit_counter_timer_test.sv
// Purpose: self-checking bench for the eight-bit timer
// Assumes: clock enable high; expectations are value ranges
// Notes:   monitor compares each bus answer or pin sample in order
`timescale 1ns/1ps
`default_nettype none
module eight_bit_counter_timer_test;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, go = 0, lvl = 0, samp = 0;
  logic [1:0]  bresp, rresp;
  logic        ea, eb, sp, lp, cp, lt, ll, len;
  typedef struct {logic [33:0] lo, hi;} ebt_exp_t;
  ebt_exp_t    q[$];
  int          err_total = 0, check_count = 0;
  ebt_timer u_dut (
    .sys_clk_in(sys_clk), .resetn_in(resetn), .clk_en_in(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .edge_input_a_in(ea), .edge_input_b_in(eb), .short_timer_pin_out(sp),
    .long_timer_pin_out(lp), .combined_timer_pin_out(cp), .long_level_in(ll),
    .long_terminal_in(lt), .long_enable_out(len), .irq_out(irq));
  ebt_pin_model u_pins (
    .sys_clk_in(sys_clk), .go_in(go), .level_in(lvl),
    .edge_a_out(ea), .edge_b_out(eb), .level_out(ll), .terminal_out(lt));
  initial forever #4 sys_clk = ~sys_clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [33:0] v);
    ebt_exp_t e;
    e = q.pop_front();
    check_count++;
    if ((^v === 1'bx) || v < e.lo || v > e.hi) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h..%h", $time, v, e.lo, e.hi);
    end
  endtask
  // Negedge view: handshake seen here completes at the next rising edge
  always @(negedge sys_clk) begin
    if ((bvalid && bready) || (rvalid && rready) || samp)
      chk(samp ? {29'h0, len, irq, cp, lp, sp} : (bvalid ? {bresp, 32'h0} : {rresp, rdata}));
  end
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] lo, hi);
    bit ga, gw, dn;
    q.push_back('{lo, hi});
    @(posedge sys_clk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    dn = 0;
    for (int n = 0; n < 200 && !dn; n++) begin
      @(negedge sys_clk);
      ga = awready | arready;
      gw = wready;
      dn = bvalid | rvalid;
      @(posedge sys_clk);
      if (ga) awvalid <= 0;
      if (ga) arvalid <= 0;
      if (gw) wvalid <= 0;
      if (dn) bready <= 0;
      if (dn) rready <= 0;
    end
  endtask
  task automatic wr(input logic [7:0] a, d); bus(1, a, {24'h0, d}, 34'h0, 34'h0); endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] lo, hi); bus(0, a, 32'h0, lo, hi); endtask
  task automatic look(input logic [3:0] v);
    q.push_back('{{30'h0, v}, {30'h0, v}});
    samp <= 1;
    @(posedge sys_clk);
    samp <= 0;
  endtask
  task automatic wait_irq(input int lim);
    for (int i = 0; i < lim && !irq; i++) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  function automatic logic comb(input logic [1:0] s, input logic a, b);
    case (s)
      2'b00: return a & b;
      2'b01: return a | b;
      2'b10: return !(a & b);
      default: return !(a | b);
    endcase
  endfunction
  // Whole run is under a thousand cycles; this limit is 25000 cycles
  initial begin
    #200000;
    err_total++;
    complete_run;
  end
  initial begin
    int n;
    void'($urandom(32'hFFCCFF3B));
    repeat (5) @(posedge sys_clk);
    resetn <= 1;
    rd(8'h0C, 34'h1F, 34'h1F);
    wr(8'h0C, 8'h00);
    rd(8'h0C, 34'h1F, 34'h1F);
    rd(8'h14, 34'hFF, 34'hFF);
    bus(1, 8'h40, 32'h5, 34'h200000000, 34'h200000000);
    rd(8'h40, 34'h200000000, 34'h2FFFFFFFF);
    wr(8'h00, 8'h01);
    wr(8'h08, 8'h01);
    for (int k = 0; k < 16; k++) begin
      lvl <= k[0];
      wr(8'h04, {2'b01, k[3:2], 2'b00, k[1], 1'b0});
      repeat (6) @(posedge sys_clk);
      look({1'b0, comb(k[3:2], !k[1], k[0]), k[0], !k[1]});
    end
    n = 8 + $urandom % 24;
    wr(8'h10, n[7:0]);
    wr(8'h24, 8'h03);
    wr(8'h04, 8'h00);
    repeat (6) @(posedge sys_clk);
    look({2'b00, lvl, 1'b1});
    wr(8'h00, 8'hC3);
    repeat (3) @(posedge sys_clk);
    look({2'b00, lvl, 1'b0});
    repeat (n - 6) @(posedge sys_clk);
    look({2'b00, lvl, 1'b0});
    wait_irq(60);
    repeat (3) @(posedge sys_clk);
    look({2'b10, lvl, 1'b1});
    rd(8'h00, 34'h63, 34'h63);
    rd(8'h2C, 34'h0, 34'h0);
    wr(8'h00, 8'h00);
    wr(8'h28, 8'h03);
    look({2'b00, lvl, 1'b0});
    wr(8'h10, 8'h10);
    wr(8'h14, 8'hFF);
    wr(8'h00, 8'h83);
    wr(8'h14, 8'h14);
    repeat (22) @(posedge sys_clk);
    look({2'b00, lvl, 1'b1});
    wait_irq(40);
    repeat (3) @(posedge sys_clk);
    look({2'b10, lvl, 1'b0});
    wr(8'h00, 8'h00);
    wr(8'h28, 8'h03);
    wr(8'h10, 8'h00);
    wr(8'h00, 8'h83);
    repeat (10) @(posedge sys_clk);
    rd(8'h20, 34'h0, 34'h0);
    rd(8'h2C, 34'hE0, 34'hFE);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'hFF);
    wr(8'h14, 8'hFF);
    wr(8'h04, 8'h3C);
    wr(8'h00, 8'h90);
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    repeat (130) @(posedge sys_clk);
    rd(8'h1C, 34'd18, 34'd22);
    rd(8'h18, 34'd58, 34'd62);
    wr(8'h00, 8'h00);
    wr(8'h10, 8'h08);
    wr(8'h00, 8'h88);
    repeat (12) @(posedge sys_clk);
    rd(8'h20, 34'h3, 34'h3);
    complete_run;
  end
endmodule
`default_nettype wire
